// ### hw/cmc_delay.sv
`timescale 1ns/100ps
module cmc_delay (
   input  wire logic       mclk,
   input  wire logic       rst,
   input  wire logic       level_raw,
   input  wire logic       tick,
   input  wire logic [4:0] limit,
   output logic            out_q
);
   logic       lvl_s1_q;
   logic       lvl_s2_q;
   logic [4:0] cnt_q;

   ////////////////////////////////////////////////////////////////////////////
   // Rising edge held back by limit ticks, falling edge passes at once
   always_ff @(posedge mclk) begin
      if (rst) begin
         lvl_s1_q <= 1'b0;
         lvl_s2_q <= 1'b0;
         cnt_q    <= 5'h00;
         out_q    <= 1'b0;
      end else begin
         lvl_s1_q <= level_raw;
         lvl_s2_q <= lvl_s1_q;
         if (!lvl_s2_q) begin
            cnt_q <= 5'h00;
            out_q <= 1'b0;
         end else if (cnt_q >= limit) begin
            out_q <= 1'b1;
         end else if (tick) begin
            cnt_q <= cnt_q + 5'h01;   // First tick may be partial
         end
      end
   end

endmodule : cmc_delay

// ### hw/cmc_event_bank.sv
`timescale 1ns/100ps
module cmc_event_bank #(
   parameter logic [7:0] USED = 8'hFF
) (
   input  wire logic       mclk,
   input  wire logic       rst,
   input  wire logic [7:0] cause_raw,
   input  wire logic       mask_wr,
   input  wire logic [7:0] mask_wdata,
   input  wire logic       global_mask,
   input  wire logic       rd_clear,
   output logic      [7:0] flags_q,
   output logic      [7:0] mask_q,
   output logic            pend_q
);
   logic [7:0] cause_s1_q;
   logic [7:0] cause_s2_q;
   logic [7:0] flags_d;
   logic [7:0] eff_mask;

   ////////////////////////////////////////////////////////////////////////////
   // Global mask forces all bits masked; stored bits stay untouched
   assign eff_mask = global_mask ? 8'hFF : mask_q;                  // RULE_02 RULE_03
   // A live cause re-sets its flag even in the read cycle
   assign flags_d  = (cause_s2_q | (rd_clear ? 8'h00 : flags_q)) & USED;   // RULE_16

   always_ff @(posedge mclk) begin
      if (rst) begin
         cause_s1_q <= 8'h00;
         cause_s2_q <= 8'h00;
         flags_q    <= cmc_pkg::FLAGS_RST;
         mask_q     <= cmc_pkg::MASK_RST;                          // RULE_06
         pend_q     <= 1'b0;
      end else begin
         cause_s1_q <= cause_raw;
         cause_s2_q <= cause_s1_q;
         flags_q    <= flags_d;
         if (mask_wr) begin
            mask_q <= mask_wdata & USED;                           // RULE_06 RULE_18
         end
         pend_q     <= |(flags_q & ~eff_mask);                     // RULE_01 RULE_04 RULE_05
      end
   end

endmodule : cmc_event_bank

// ### hw/cmc_mask_config_regs.sv
// Functional notes
// RULE_01: Mask bit 1 blocks matching event interrupt.
// RULE_02: Global mask set treats all masks as 1.
// RULE_03: Global mask resets to 1; 0 uses masks.
// RULE_04: Mask one bits 7,5..2,0 gate flags one.
// RULE_05: Mask two bits 6..0 gate flags two.
// RULE_06: Mask registers read/write, reset to zero.
// RULE_07: Power-good delay code: 0, 0.25, 1, 4 ms.
// RULE_08: Bias-good delay code: 1, 1.25, 1.5, 3 ms.
// RULE_09: Servo step period base times 1,2,4,8.
// RULE_10: Discharge resistor helps downward servo when enabled.
// RULE_11: Discharge resistor on while main buck off.
// RULE_12: Set bit disables output undervoltage protection.
// RULE_13: Fault policy bit: 1 latch-off, 0 hiccup.
// RULE_14: Bias buck autostart enable, default on.
// RULE_15: Auxiliary regulator autostart enable, default on.
// RULE_16: Reading flags clears them unless cause persists.
// RULE_17: Interrupt asserted while any unmasked flag set.
// RULE_18: Unused bits read zero, ignore writes.
`timescale 1ns/100ps
module cmc_mask_config_regs #(
   parameter logic [6:0] DEV_ADDR       = cmc_pkg::DEV_ADDR_DEF,
   parameter int         QUARTER_MS_CYC = cmc_pkg::QUARTER_MS_CYC,
   parameter int         SERVO_BASE_CYC = cmc_pkg::SERVO_BASE_CYC
) (
   input  wire logic       mclk,
   input  wire logic       rst,
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   output logic            sda_out,
   output logic            sda_oe,
   input  wire logic [7:0] event_cause_one,
   input  wire logic [7:0] event_cause_two,
   input  wire logic       power_good_raw,
   input  wire logic       bias_good_raw,
   input  wire logic       buck_enabled,
   input  wire logic       servo_down,
   output logic            irq_n,
   output logic            power_good_out,
   output logic            bias_good_out,
   output logic            servo_tick,
   output logic            discharge_on,
   output logic            output_undervoltage_disable,
   output logic            latch_off_select,
   output logic            bias_autostart,
   output logic            auxiliary_regulator_autostart
);

   ////////////////////////////////////////////////////////////////////////////
   // Declarations
   logic                scl_s1_q;
   logic                scl_s2_q;
   logic                scl_s3_q;
   logic                sda_s1_q;
   logic                sda_s2_q;
   logic                sda_s3_q;
   cmc_pkg::cmc_i2c_st_t st_q;
   logic          [7:0] sh_q;
   logic          [7:0] tx_q;
   logic          [7:0] ptr_q;
   logic          [2:0] bit_cnt_q;
   logic                done_q;
   logic                rw_q;
   logic                nack_q;
   logic          [7:0] cfg_one_q;
   logic          [7:0] cfg_two_q;
   logic          [7:0] flags_one;
   logic          [7:0] flags_two;
   logic          [7:0] mask_one;
   logic          [7:0] mask_two;
   logic                pend_one;
   logic                pend_two;
   logic         [12:0] qms_cnt_q;
   logic                qms_tick_q;
   logic         [15:0] servo_cnt_q;
   logic         [15:0] servo_limit;
   logic          [4:0] pg_limit;
   logic          [4:0] bg_limit;
   logic          [7:0] rd_data;
   logic                scl_rise;
   logic                scl_fall;
   logic                bus_start;
   logic                bus_stop;
   logic                shift_in;
   logic                rd_take;
   logic                wr_take;
   logic                adr_match;

   ////////////////////////////////////////////////////////////////////////////
   // Pick one 5-bit quarter-ms count out of a table of four
   function automatic logic [4:0] qtr_pick(input logic [19:0] tbl, input logic [1:0] code);
      logic [4:0] r;
      r = 5'h00;
      case (code)
         2'h0:    r = tbl[4:0];
         2'h1:    r = tbl[9:5];
         2'h2:    r = tbl[14:10];
         default: r = tbl[19:15];
      endcase
      return r;
   endfunction : qtr_pick
   ////////////////////////////////////////////////////////////////////////////
   // Serial pins: two flops before use, third only for edge detect
   always_ff @(posedge mclk) begin
      if (rst) begin
         {scl_s3_q, scl_s2_q, scl_s1_q} <= 3'h7;   // Idle-high, so no false start
         {sda_s3_q, sda_s2_q, sda_s1_q} <= 3'h7;
      end else begin
         {scl_s3_q, scl_s2_q, scl_s1_q} <= {scl_s2_q, scl_s1_q, scl_in};
         {sda_s3_q, sda_s2_q, sda_s1_q} <= {sda_s2_q, sda_s1_q, sda_in};
      end
   end
   // Bus events and transfer decisions
   assign scl_rise  = scl_s2_q & ~scl_s3_q;
   assign scl_fall  = ~scl_s2_q & scl_s3_q;
   assign bus_start = scl_s2_q & scl_s3_q & sda_s3_q & ~sda_s2_q;
   assign bus_stop  = scl_s2_q & scl_s3_q & ~sda_s3_q & sda_s2_q;
   assign shift_in  = (st_q == cmc_pkg::I_ADDR) || (st_q == cmc_pkg::I_PTR) ||
                      (st_q == cmc_pkg::I_WDATA) || (st_q == cmc_pkg::I_RDATA);
   assign adr_match = (sh_q[7:1] == DEV_ADDR);
   assign rd_take   = scl_fall && !bus_start && !bus_stop &&
                      (((st_q == cmc_pkg::I_ACK_ADDR) && rw_q) ||
                       ((st_q == cmc_pkg::I_RACK) && !nack_q));
   assign wr_take   = scl_fall && !bus_start && !bus_stop &&
                      (st_q == cmc_pkg::I_WDATA) && done_q;

   ////////////////////////////////////////////////////////////////////////////
   // Byte engine: sample on clock rise, change the data line on fall
   always_ff @(posedge mclk) begin
      if (rst) begin
         st_q      <= cmc_pkg::I_IDLE;
         sh_q      <= 8'h00;
         tx_q      <= 8'h00;
         ptr_q     <= 8'h00;
         bit_cnt_q <= 3'h0;
         done_q    <= 1'b0;
         rw_q      <= 1'b0;
         nack_q    <= 1'b0;
         sda_oe    <= 1'b0;
         sda_out   <= 1'b0;
      end else if (bus_start) begin
         st_q      <= cmc_pkg::I_ADDR;   // Repeated start keeps the pointer
         bit_cnt_q <= 3'h0;
         done_q    <= 1'b0;
         sda_oe    <= 1'b0;
      end else if (bus_stop) begin
         st_q   <= cmc_pkg::I_IDLE;
         done_q <= 1'b0;
         sda_oe <= 1'b0;
      end else if (scl_rise) begin
         if (shift_in) begin
            sh_q      <= {sh_q[6:0], sda_s2_q};
            bit_cnt_q <= bit_cnt_q + 3'h1;
            done_q    <= (bit_cnt_q == 3'h7);
         end else if (st_q == cmc_pkg::I_RACK) begin
            nack_q <= sda_s2_q;
         end
      end else if (scl_fall) begin
         done_q <= 1'b0;
         case (st_q)
            cmc_pkg::I_ADDR: begin
               if (done_q && adr_match) begin
                  rw_q   <= sh_q[0];
                  sda_oe <= 1'b1;
                  st_q   <= cmc_pkg::I_ACK_ADDR;
               end else if (done_q) begin
                  st_q <= cmc_pkg::I_IDLE;      // Not ours, wait for start
               end
            end
            cmc_pkg::I_ACK_ADDR, cmc_pkg::I_RACK: begin
               if (rd_take) begin
                  tx_q   <= rd_data;
                  sda_oe <= ~rd_data[7];
                  ptr_q  <= ptr_q + 8'h01;
                  st_q   <= cmc_pkg::I_RDATA;
               end else if (st_q == cmc_pkg::I_ACK_ADDR) begin
                  sda_oe <= 1'b0;
                  st_q   <= cmc_pkg::I_PTR;
               end else begin
                  st_q <= cmc_pkg::I_IDLE;      // Master refused more
               end
            end
            cmc_pkg::I_PTR: begin
               if (done_q) begin
                  ptr_q  <= sh_q;
                  sda_oe <= 1'b1;
                  st_q   <= cmc_pkg::I_ACK_PTR;
               end
            end
            cmc_pkg::I_ACK_PTR, cmc_pkg::I_ACK_WDATA: begin
               sda_oe <= 1'b0;
               st_q   <= cmc_pkg::I_WDATA;
            end
            cmc_pkg::I_WDATA: begin
               if (wr_take) begin
                  ptr_q  <= ptr_q + 8'h01;
                  sda_oe <= 1'b1;
                  st_q   <= cmc_pkg::I_ACK_WDATA;
               end
            end
            cmc_pkg::I_RDATA: begin
               if (done_q) begin
                  sda_oe <= 1'b0;
                  st_q   <= cmc_pkg::I_RACK;
               end else begin
                  tx_q   <= {tx_q[6:0], 1'b0};
                  sda_oe <= ~tx_q[6];
               end
            end
            default: begin
               sda_oe <= 1'b0;
               st_q   <= cmc_pkg::I_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read data; unmapped offsets read zero
   assign rd_data = (ptr_q == cmc_pkg::ADR_FLAGS_ONE) ? flags_one :
                    (ptr_q == cmc_pkg::ADR_FLAGS_TWO) ? flags_two :
                    (ptr_q == cmc_pkg::ADR_MASK_ONE)  ? mask_one  :
                    (ptr_q == cmc_pkg::ADR_MASK_TWO)  ? mask_two  :
                    (ptr_q == cmc_pkg::ADR_CFG_ONE)   ? cfg_one_q :
                    (ptr_q == cmc_pkg::ADR_CFG_TWO)   ? cfg_two_q :
                    cmc_pkg::READ_NONE;

   ////////////////////////////////////////////////////////////////////////////
   // Event flags and masks, one bank per flag register
   cmc_event_bank #(.USED(cmc_pkg::USED_ONE)) u_bank_one (
      .mclk        (mclk),
      .rst         (rst),
      .cause_raw   (event_cause_one),
      .mask_wr     (wr_take && (ptr_q == cmc_pkg::ADR_MASK_ONE)),
      .mask_wdata  (sh_q),
      .global_mask (cfg_one_q[cmc_pkg::GLOBAL_MASK]),
      .rd_clear    (rd_take && (ptr_q == cmc_pkg::ADR_FLAGS_ONE)),
      .flags_q     (flags_one),
      .mask_q      (mask_one),
      .pend_q      (pend_one)
   );
   cmc_event_bank #(.USED(cmc_pkg::USED_TWO)) u_bank_two (
      .mclk        (mclk),
      .rst         (rst),
      .cause_raw   (event_cause_two),
      .mask_wr     (wr_take && (ptr_q == cmc_pkg::ADR_MASK_TWO)),
      .mask_wdata  (sh_q),
      .global_mask (cfg_one_q[cmc_pkg::GLOBAL_MASK]),
      .rd_clear    (rd_take && (ptr_q == cmc_pkg::ADR_FLAGS_TWO)),
      .flags_q     (flags_two),
      .mask_q      (mask_two),
      .pend_q      (pend_two)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Configuration bytes; unused bits never store
   always_ff @(posedge mclk) begin
      if (rst) begin
         cfg_one_q <= cmc_pkg::CFG_ONE_RST;                        // RULE_03
         cfg_two_q <= cmc_pkg::CFG_TWO_RST;
      end else if (wr_take && (ptr_q == cmc_pkg::ADR_CFG_ONE)) begin
         cfg_one_q <= sh_q & cmc_pkg::USED_CFG_ONE;                // RULE_18
      end else if (wr_take && (ptr_q == cmc_pkg::ADR_CFG_TWO)) begin
         cfg_two_q <= sh_q & cmc_pkg::USED_CFG_TWO;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Quarter-ms enable for both pin delays
   always_ff @(posedge mclk) begin
      if (rst) begin
         qms_cnt_q  <= 13'h0000;
         qms_tick_q <= 1'b0;
      end else if (qms_cnt_q >= 13'(QUARTER_MS_CYC - 1)) begin
         qms_cnt_q  <= 13'h0000;
         qms_tick_q <= 1'b1;
      end else begin
         qms_cnt_q  <= qms_cnt_q + 13'h0001;
         qms_tick_q <= 1'b0;
      end
   end
   // Delay lengths chosen by the two codes
   assign pg_limit = qtr_pick(cmc_pkg::PG_DLY_QTR,
                              cfg_one_q[cmc_pkg::PG_DLY_LSB +: 2]);   // RULE_07
   assign bg_limit = qtr_pick(cmc_pkg::BG_DLY_QTR,
                              cfg_one_q[cmc_pkg::BG_DLY_LSB +: 2]);   // RULE_08
   cmc_delay u_power_good_delay_code (
      .mclk      (mclk),
      .rst       (rst),
      .level_raw (power_good_raw),
      .tick      (qms_tick_q),
      .limit     (pg_limit),
      .out_q     (power_good_out)
   );
   cmc_delay u_bg_delay (
      .mclk      (mclk),
      .rst       (rst),
      .level_raw (bias_good_raw),
      .tick      (qms_tick_q),
      .limit     (bg_limit),
      .out_q     (bias_good_out)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Servo step period: base shifted by code; a shorter code takes at once
   assign servo_limit = 16'((SERVO_BASE_CYC << cfg_two_q[cmc_pkg::SERVO_LSB +: 2]) - 1);
   always_ff @(posedge mclk) begin
      if (rst) begin
         servo_cnt_q <= 16'h0000;
         servo_tick  <= 1'b0;
      end else if (servo_cnt_q >= servo_limit) begin
         servo_cnt_q <= 16'h0000;
         servo_tick  <= 1'b1;                                      // RULE_09
      end else begin
         servo_cnt_q <= servo_cnt_q + 16'h0001;
         servo_tick  <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Control outputs and interrupt line, all registered
   always_ff @(posedge mclk) begin
      if (rst) begin
         irq_n                         <= 1'b1;
         discharge_on                  <= 1'b0;
         output_undervoltage_disable   <= 1'b0;
         latch_off_select              <= 1'b0;
         bias_autostart                <= 1'b0;
         auxiliary_regulator_autostart <= 1'b0;
      end else begin
         irq_n                         <= ~(pend_one | pend_two);  // RULE_17
         discharge_on                  <=
            (servo_down & cfg_two_q[cmc_pkg::DIS_SERVO]) |         // RULE_10
            (~buck_enabled & cfg_two_q[cmc_pkg::DIS_OFF]);         // RULE_11
         output_undervoltage_disable   <= cfg_two_q[cmc_pkg::NO_UVP];     // RULE_12
         latch_off_select              <= cfg_two_q[cmc_pkg::LATCH_OFF];  // RULE_13
         bias_autostart                <= cfg_two_q[cmc_pkg::BIAS_AUTO];  // RULE_14
         auxiliary_regulator_autostart <= cfg_two_q[cmc_pkg::AUX_AUTO];   // RULE_15
      end
   end
endmodule : cmc_mask_config_regs

// ### hw/cmc_pkg.sv
package cmc_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Register offsets
   localparam logic [7:0] ADR_FLAGS_ONE = 8'h01;
   localparam logic [7:0] ADR_FLAGS_TWO = 8'h02;
   localparam logic [7:0] ADR_MASK_ONE  = 8'h06;
   localparam logic [7:0] ADR_MASK_TWO  = 8'h07;
   localparam logic [7:0] ADR_CFG_ONE   = 8'h08;
   localparam logic [7:0] ADR_CFG_TWO   = 8'h09;

   ////////////////////////////////////////////////////////////////////////////
   // Implemented bits and values after reset
   localparam logic [7:0] USED_ONE      = 8'hBD;
   localparam logic [7:0] USED_TWO      = 8'h7F;
   localparam logic [7:0] USED_CFG_ONE  = 8'hF8;
   localparam logic [7:0] USED_CFG_TWO  = 8'hFF;
   localparam logic [7:0] MASK_RST      = 8'h00;
   localparam logic [7:0] FLAGS_RST     = 8'h00;
   localparam logic [7:0] CFG_ONE_RST   = 8'h28;
   localparam logic [7:0] CFG_TWO_RST   = 8'hF3;
   localparam logic [7:0] READ_NONE     = 8'h00;

   ////////////////////////////////////////////////////////////////////////////
   // Field positions
   localparam int PG_DLY_LSB    = 6;
   localparam int GLOBAL_MASK   = 5;
   localparam int BG_DLY_LSB    = 3;
   localparam int SERVO_LSB     = 6;
   localparam int DIS_SERVO     = 5;
   localparam int DIS_OFF       = 4;
   localparam int NO_UVP        = 3;
   localparam int LATCH_OFF     = 2;
   localparam int BIAS_AUTO     = 1;
   localparam int AUX_AUTO      = 0;

   ////////////////////////////////////////////////////////////////////////////
   // Timing: delays are counted in quarter milliseconds
   localparam int CLK_PERIOD_NS  = 40;
   localparam int QUARTER_MS_NS  = 250000;
   localparam int QUARTER_MS_CYC = QUARTER_MS_NS / CLK_PERIOD_NS;
   localparam int SERVO_BASE_NS  = 1000;
   localparam int SERVO_BASE_CYC = (SERVO_BASE_NS / CLK_PERIOD_NS < 1) ? 1 :
                                   SERVO_BASE_NS / CLK_PERIOD_NS;
   // Quarter-ms counts per code, code 3 in the top slice
   localparam logic [19:0] PG_DLY_QTR = {5'h10, 5'h04, 5'h01, 5'h00};
   localparam logic [19:0] BG_DLY_QTR = {5'h0C, 5'h06, 5'h05, 5'h04};

   // Bus address of the serial port, value arbitrary
   localparam logic [6:0] DEV_ADDR_DEF = 7'h2C;

   typedef enum logic [3:0] {
      I_IDLE, I_ADDR, I_ACK_ADDR, I_PTR, I_ACK_PTR,
      I_WDATA, I_ACK_WDATA, I_RDATA, I_RACK
   } cmc_i2c_st_t;

endpackage : cmc_pkg

// ### test/cmc_chk_sva.sv
`timescale 1ns/100ps
module cmc_chk (
   input wire logic mclk,
   input wire logic rst,
   input wire logic sda_out,
   input wire logic irq_n,
   input wire logic power_good_raw,
   input wire logic power_good_out,
   input wire logic bias_good_raw,
   input wire logic bias_good_out,
   input wire logic servo_tick,
   input wire logic servo_down,
   input wire logic buck_enabled,
   input wire logic discharge_on,
   input wire logic bias_autostart,
   input wire logic auxiliary_regulator_autostart,
   input wire logic latch_off_select
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);

   ////////////////////////////////////////////////////////////////////////////
   // Reset values and the masked start-up window
   reset_cfg_a: assert property ($fell(rst) |=> bias_autostart
      && auxiliary_regulator_autostart && !latch_off_select) else $error("cfg reset value");
   irq_quiet_a: assert property ($fell(rst) |-> irq_n [*8])
      else $error("irq after reset");
   // Step pulse never merges into a level
   servo_pulse_a: assert property (servo_tick |=> !servo_tick)
      else $error("servo tick too long");
   dis_idle_a: assert property (buck_enabled && !servo_down |=> !discharge_on)
      else $error("discharge without cause");
   // Falling good inputs pass with no delay beyond the two-flop synchroniser and the output flop
   pg_fall_a: assert property ((!power_good_raw) [*4] |-> !power_good_out)
      else $error("power good late fall");
   bg_fall_a: assert property ((!bias_good_raw) [*4] |-> !bias_good_out)
      else $error("bias good late fall");
   pg_rise_a: assert property ($rose(power_good_out) |-> $past(power_good_raw, 3))
      else $error("power good without input");
   bg_rise_a: assert property ($rose(bias_good_out) |-> $past(bias_good_raw, 3)
      && $past(bias_good_raw, 4)) else $error("bias good without input");
   od_low_a: assert property (!sda_out) else $error("data pin driven high");
endmodule : cmc_chk

bind cmc_mask_config_regs cmc_chk cmc_chk_i (.mclk, .rst, .sda_out, .irq_n, .power_good_raw,
   .power_good_out, .bias_good_raw, .bias_good_out, .servo_tick, .servo_down, .buck_enabled,
   .discharge_on, .bias_autostart, .auxiliary_regulator_autostart, .latch_off_select);

// ### test/cmc_host.sv
`timescale 1ns/100ps
module cmc_host #(
   parameter logic [6:0] ADDR = cmc_pkg::DEV_ADDR_DEF
) (
   input  wire logic mclk,
   input  wire logic sda_oe,
   output logic      scl,
   output logic      sda
);
   logic drv_low;
   // Open drain with pull-up: a released line reads high
   assign sda = ~(drv_low | sda_oe);
   initial begin
      scl = 1'b1;
      drv_low = 1'b0;
   end
   task automatic w(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : w
   // One extra cycle after the fall keeps data hold clear of the clock edge
   task automatic bit_io(input logic b, output logic r);
      drv_low = ~b;
      w(5);
      scl = 1'b1;
      w(3);
      r = sda;
      w(2);
      scl = 1'b0;
      w(1);
   endtask : bit_io
   task automatic start();
      drv_low = 1'b0;
      w(5);
      scl = 1'b1;
      w(5);
      drv_low = 1'b1;
      w(5);
      scl = 1'b0;
      w(1);
   endtask : start
   task automatic stop();
      drv_low = 1'b1;
      w(5);
      scl = 1'b1;
      w(5);
      drv_low = 1'b0;
      w(5);
   endtask : stop
   task automatic xfer(input logic [7:0] tx, input logic ai, output logic [7:0] rx,
                       output logic ao);
      for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
      bit_io(ai, ao);
   endtask : xfer
   task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [2:0] k);
      logic [7:0] x;
      start();
      xfer({ADDR, 1'b0}, 1'b1, x, k[2]);
      xfer(a, 1'b1, x, k[1]);
      xfer(d, 1'b1, x, k[0]);
      stop();
   endtask : wr
   // Pointer write, repeated start, one byte then a refusal to end the read
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      logic [7:0] x;
      logic       k;
      start();
      xfer({ADDR, 1'b0}, 1'b1, x, k);
      xfer(a, 1'b1, x, k);
      start();
      xfer({ADDR, 1'b1}, 1'b1, x, k);
      xfer(8'hFF, 1'b1, d, k);
      stop();
   endtask : rd
endmodule : cmc_host

// ### test/tb.sv
`timescale 1ns/100ps
module tb;
   logic mclk, rst, scl, sda, sda_out, sda_oe, irq_n, servo_tick, discharge_on;
   logic power_good_raw, bias_good_raw, buck_enabled, servo_down, power_good_out;
   logic bias_good_out, output_undervoltage_disable, latch_off_select, bias_autostart;
   logic auxiliary_regulator_autostart;
   logic [7:0] event_cause_one, event_cause_two, rd_d;
   int n_errors, check_count, c;
   int pg_q[4] = '{0, 1, 4, 16};
   int bg_q[4] = '{4, 5, 6, 12};

   cmc_mask_config_regs #(.QUARTER_MS_CYC(10), .SERVO_BASE_CYC(2)) cmc_mask_config_regs_i (
      .mclk, .rst, .scl_in(scl), .sda_in(sda), .sda_out, .sda_oe, .event_cause_one,
      .event_cause_two, .power_good_raw, .bias_good_raw, .buck_enabled, .servo_down, .irq_n,
      .power_good_out, .bias_good_out, .servo_tick, .discharge_on, .output_undervoltage_disable,
      .latch_off_select, .bias_autostart, .auxiliary_regulator_autostart);
   cmc_host cmc_host_i (.mclk, .sda_oe, .scl, .sda);

   always #20 mclk = ~mclk;

   ////////////////////////////////////////////////////////////////////////////
   task automatic w(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : w
   task automatic cmp8(input logic [7:0] g, input logic [7:0] e);
      check_count++;
      if (g !== e) begin
         n_errors++;
         $display("mismatch t=%0t got %0h exp %0h", $time, g, e);
      end
   endtask : cmp8
   task automatic cmp_in(input int g, input int lo, input int hi);
      check_count++;
      if (g < lo || g > hi) begin
         n_errors++;
         $display("mismatch t=%0t got %0h exp %0h..%0h", $time, g, lo, hi);
      end
   endtask : cmp_in
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [2:0] k;
      cmc_host_i.wr(a, d, k);
      cmp8({5'h00, k}, 8'h00);
   endtask : wr
   task automatic rdc(input logic [7:0] a, input logic [7:0] e);
      cmc_host_i.rd(a, rd_d);
      cmp8(rd_d, e);
   endtask : rdc
   task automatic irq(input logic e);
      w(4);
      cmp8({7'h00, irq_n}, {7'h00, e});
   endtask : irq
   // Rise delay in whole quarters, first quarter may be partial
   task automatic dly(input bit bias, input int n);
      c = 0;
      if (bias) bias_good_raw = 1'b1;
      else power_good_raw = 1'b1;
      while (((bias ? bias_good_out : power_good_out) !== 1'b1) && c < 400) begin
         w(1);
         c++;
      end
      cmp_in(c, (n > 0) ? (n - 1) * 10 + 3 : 3, n * 10 + 3);
      bias_good_raw = 1'b0;
      power_good_raw = 1'b0;
      w(6);
   endtask : dly
   task automatic servo(input int code);
      wr(cmc_pkg::ADR_CFG_TWO, {code[1:0], 6'h30});
      c = 0;
      while (servo_tick !== 1'b1 && c < 100) begin
         w(1);
         c++;
      end
      w(1);
      c = 1;
      while (servo_tick !== 1'b1 && c < 100) begin
         w(1);
         c++;
      end
      cmp_in(c, 2 << code, 2 << code);
   endtask : servo
   task automatic close_out();
      $display("errors %0d checks %0d", n_errors, check_count);
      if (n_errors == 0 && check_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : close_out

   ////////////////////////////////////////////////////////////////////////////
   // Watchdog sized well past the longest sequence
   initial begin
      #(40 * 40000);
      n_errors++;
      close_out();
   end
   initial begin
      mclk = 1'b0;
      rst = 1'b1;
      event_cause_one = 8'h00;
      event_cause_two = 8'h00;
      {power_good_raw, bias_good_raw, servo_down} = 3'h0;
      buck_enabled = 1'b1;
      n_errors = 0;
      check_count = 0;
      w(2);
      rst = 1'b0;
      w(4);
      rdc(cmc_pkg::ADR_MASK_ONE, 8'h00);
      rdc(cmc_pkg::ADR_MASK_TWO, 8'h00);
      rdc(cmc_pkg::ADR_CFG_ONE, 8'h28);
      rdc(cmc_pkg::ADR_CFG_TWO, 8'hF3);
      rdc(8'h0F, 8'h00);
      wr(cmc_pkg::ADR_MASK_ONE, 8'hFF);
      rdc(cmc_pkg::ADR_MASK_ONE, 8'hBD);
      wr(cmc_pkg::ADR_MASK_TWO, 8'hFF);
      rdc(cmc_pkg::ADR_MASK_TWO, 8'h7F);
      wr(cmc_pkg::ADR_CFG_ONE, 8'hFF);
      rdc(cmc_pkg::ADR_CFG_ONE, 8'hF8);
      // Live cause held back by the global mask, then by its own bit
      wr(cmc_pkg::ADR_MASK_ONE, 8'h00);
      wr(cmc_pkg::ADR_CFG_ONE, 8'h28);
      event_cause_one = 8'h01;
      irq(1'b1);
      wr(cmc_pkg::ADR_CFG_ONE, 8'h08);
      irq(1'b0);
      wr(cmc_pkg::ADR_MASK_ONE, 8'h01);
      irq(1'b1);
      wr(cmc_pkg::ADR_MASK_ONE, 8'h00);
      irq(1'b0);
      event_cause_one = 8'h00;
      rdc(cmc_pkg::ADR_FLAGS_ONE, 8'h01);
      irq(1'b1);
      rdc(cmc_pkg::ADR_FLAGS_ONE, 8'h00);
      wr(cmc_pkg::ADR_MASK_TWO, 8'h40);
      event_cause_two = 8'h40;
      irq(1'b1);
      wr(cmc_pkg::ADR_MASK_TWO, 8'h00);
      irq(1'b0);
      event_cause_two = 8'h00;
      rdc(cmc_pkg::ADR_FLAGS_TWO, 8'h40);
      irq(1'b1);
      // Config outputs and both discharge causes
      wr(cmc_pkg::ADR_CFG_TWO, 8'h0C);
      cmp8({4'h0, output_undervoltage_disable, latch_off_select, bias_autostart,
            auxiliary_regulator_autostart}, 8'h0C);
      buck_enabled = 1'b0;
      w(2);
      cmp8({7'h00, discharge_on}, 8'h00);
      wr(cmc_pkg::ADR_CFG_TWO, 8'h10);
      cmp8({7'h00, discharge_on}, 8'h01);
      buck_enabled = 1'b1;
      servo_down = 1'b1;
      w(2);
      cmp8({7'h00, discharge_on}, 8'h00);
      wr(cmc_pkg::ADR_CFG_TWO, 8'h20);
      cmp8({7'h00, discharge_on}, 8'h01);
      servo_down = 1'b0;
      for (int k = 0; k < 4; k++) servo(k);
      for (int k = 0; k < 4; k++) begin
         wr(cmc_pkg::ADR_CFG_ONE, {k[1:0], 1'b1, k[1:0], 3'h0});
         dly(1'b0, pg_q[k]);
         dly(1'b1, bg_q[k]);
      end
      // Second reset in mid-run restores defaults
      rst = 1'b1;
      w(2);
      rst = 1'b0;
      w(4);
      rdc(cmc_pkg::ADR_CFG_TWO, 8'hF3);
      close_out();
   end
endmodule : tb
